// ---- common/dsdec_pkg.sv ----
// data-space decoder constants: address map, widths, field positions
package dsdec_pkg;
  localparam int DATA_W = 8;
  localparam int ROM_AW = 13;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 6;
  localparam int WIN_LSB_W = 6;
  localparam int PAGE_BITS_W = 7;
  localparam logic [7:0] WIN_LO = 8'h40;
  localparam logic [7:0] WIN_HI = 8'h7F;
  localparam logic [7:0] RAM_LO = 8'h84;
  localparam logic [7:0] RAM_HI = 8'hBF;
  localparam logic [7:0] PTR_ONE_ADDR = 8'h80;
  localparam logic [7:0] PTR_TWO_ADDR = 8'h81;
  localparam logic [7:0] SD_ONE_ADDR = 8'h82;
  localparam logic [7:0] SD_TWO_ADDR = 8'h83;
  localparam logic [7:0] PA_DATA_ADDR = 8'hC0;
  localparam logic [7:0] PB_DATA_ADDR = 8'hC1;
  localparam logic [7:0] PA_DIR_ADDR = 8'hC4;
  localparam logic [7:0] PB_DIR_ADDR = 8'hC5;
  localparam logic [7:0] INT_OPT_ADDR = 8'hC8;
  localparam logic [7:0] WIN_PAGE_ADDR = 8'hC9;
  localparam logic [7:0] PA_OPT_ADDR = 8'hCC;
  localparam logic [7:0] PB_OPT_ADDR = 8'hCD;
  localparam logic [7:0] CONV_RES_ADDR = 8'hD0;
  localparam logic [7:0] CONV_CTL_ADDR = 8'hD1;
  localparam logic [7:0] TMR_PSC_ADDR = 8'hD2;
  localparam logic [7:0] TMR_CNT_ADDR = 8'hD3;
  localparam logic [7:0] TMR_SC_ADDR = 8'hD4;
  localparam logic [7:0] WDG_ADDR = 8'hD8;
  localparam logic [7:0] ACC_ADDR = 8'hFF;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam int NUM_PERIPH = 14;
  typedef enum logic [1:0] {DSDEC_PC_HOLD, DSDEC_PC_LOAD, DSDEC_PC_INC} dsdec_pc_op_t;
  typedef enum logic [1:0] {DSDEC_STK_NONE, DSDEC_STK_PUSH, DSDEC_STK_POP} dsdec_stk_op_t;
endpackage

// ---- logic/dsdec_top.sv ----
// data-space decoder: core registers, ram, rom window, peripheral selects, pc, stack
// Notes on behaviour
// - data addresses 40h..7Fh read program rom bytes, not ram
// - rom address is page register above low six data address bits
// - window moves only in whole 64-byte pages chosen by page register
// - window reads can reach rom 0000h..1FFFh, limited by rom fitted
// - page register at C9h is write-only; reads do not return it
// - page register is not touched by reset, so starts undefined
// - page bit 7 ignored; bits 6..0 form upper rom address
// - sixty bytes of general ram at 84h..BFh
// - both pointer registers are ordinary data locations at 80h and 81h
// - both short-direct registers are ordinary data locations at 82h and 83h
// - accumulator is an ordinary data location at FFh
// - program counter is twelve bits wide, 4096 bytes direct
// - six separate twelve-bit return-address stack registers
// - port data, direction and option registers decoded at their offsets
// - interrupt option register at C8h is write-only
// - blown protection fuse blocks all external rom readout
module dsdec_top #(
  parameter int ROM_AW = dsdec_pkg::ROM_AW,
  parameter int STACK_DEPTH = dsdec_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // core data-space bus
  input wire logic [7:0] core_addr_i,
  input wire logic [7:0] core_wdata_i,
  input wire logic core_rd_i,
  input wire logic core_wr_i,
  output logic [7:0] core_rdata_o,
  // program counter and stack control from the core sequencer
  input wire dsdec_pkg::dsdec_pc_op_t pc_op_i,
  input wire logic [11:0] pc_load_i,
  input wire dsdec_pkg::dsdec_stk_op_t stk_op_i,
  output logic [11:0] instruction_pointer_o,
  // program rom port (combinational address, data back in same cycle)
  output logic [ROM_AW-1:0] rom_addr_o,
  input wire logic [7:0] rom_data_i,
  // external readout request and fuse state
  input wire logic readout_prot_fuse_i,
  input wire logic ext_read_req_i,
  input wire logic [ROM_AW-1:0] ext_read_addr_i,
  output logic [7:0] ext_read_data_o,
  output logic ext_read_blocked_o,
  // peripheral register selects and data
  output logic [dsdec_pkg::NUM_PERIPH-1:0] periph_sel_o,
  output logic periph_wr_o,
  output logic periph_rd_o,
  output logic [7:0] periph_wdata_o,
  input wire logic [7:0] periph_rdata_i,
  output logic [6:0] window_page_bits_o
);

  ////////////////////////////////////////////////////////////////////////
  // address decode

  logic win_hit;
  logic ram_hit;
  logic wpage_hit;
  logic ptr1_hit;
  logic ptr2_hit;
  logic sd1_hit;
  logic sd2_hit;
  logic acc_hit;
  logic [dsdec_pkg::NUM_PERIPH-1:0] psel;
  logic periph_ro_blocked;

  assign win_hit = (core_addr_i >= dsdec_pkg::WIN_LO) && (core_addr_i <= dsdec_pkg::WIN_HI);
  assign ram_hit = (core_addr_i >= dsdec_pkg::RAM_LO) && (core_addr_i <= dsdec_pkg::RAM_HI);
  assign wpage_hit = core_addr_i == dsdec_pkg::WIN_PAGE_ADDR;
  assign ptr1_hit = core_addr_i == dsdec_pkg::PTR_ONE_ADDR;
  assign ptr2_hit = core_addr_i == dsdec_pkg::PTR_TWO_ADDR;
  assign sd1_hit = core_addr_i == dsdec_pkg::SD_ONE_ADDR;
  assign sd2_hit = core_addr_i == dsdec_pkg::SD_TWO_ADDR;
  assign acc_hit = core_addr_i == dsdec_pkg::ACC_ADDR;
  // holes match no decode and read as fill

  assign psel[0] = core_addr_i == dsdec_pkg::PA_DATA_ADDR;
  assign psel[1] = core_addr_i == dsdec_pkg::PB_DATA_ADDR;
  assign psel[2] = core_addr_i == dsdec_pkg::PA_DIR_ADDR;
  assign psel[3] = core_addr_i == dsdec_pkg::PB_DIR_ADDR;
  assign psel[4] = core_addr_i == dsdec_pkg::INT_OPT_ADDR;
  assign psel[5] = core_addr_i == dsdec_pkg::PA_OPT_ADDR;
  assign psel[6] = core_addr_i == dsdec_pkg::PB_OPT_ADDR;
  assign psel[7] = core_addr_i == dsdec_pkg::CONV_RES_ADDR;
  assign psel[8] = core_addr_i == dsdec_pkg::CONV_CTL_ADDR;
  assign psel[9] = core_addr_i == dsdec_pkg::TMR_PSC_ADDR;
  assign psel[10] = core_addr_i == dsdec_pkg::TMR_CNT_ADDR;
  assign psel[11] = core_addr_i == dsdec_pkg::TMR_SC_ADDR;
  assign psel[12] = core_addr_i == dsdec_pkg::WDG_ADDR;
  // spare select, kept low
  assign psel[13] = 1'b0;

  // interrupt option is write-only: no read strobe
  assign periph_ro_blocked = psel[4];
  assign periph_sel_o = psel;
  assign periph_wr_o = core_wr_i && (|psel);
  assign periph_rd_o = core_rd_i && (|psel) && !periph_ro_blocked;
  assign periph_wdata_o = core_wdata_i;

  ////////////////////////////////////////////////////////////////////////
  // core registers held in data space

  logic [7:0] ptr_one_ff;
  logic [7:0] ptr_two_ff;
  logic [7:0] sd_one_ff;
  logic [7:0] sd_two_ff;
  logic [7:0] acc_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      ptr_one_ff <= 8'h00;
      ptr_two_ff <= 8'h00;
    end
    else if (core_wr_i)
    begin
      if (ptr1_hit)
        ptr_one_ff <= core_wdata_i;
      if (ptr2_hit)
        ptr_two_ff <= core_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      sd_one_ff <= 8'h00;
      sd_two_ff <= 8'h00;
    end
    else if (core_wr_i)
    begin
      if (sd1_hit)
        sd_one_ff <= core_wdata_i;
      if (sd2_hit)
        sd_two_ff <= core_wdata_i;
    end
  end

  // accumulator at top of data space
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      acc_ff <= 8'h00;
    else if (core_wr_i && acc_hit)
      acc_ff <= core_wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // general ram

  localparam int RAM_WORDS = int'(dsdec_pkg::RAM_HI) - int'(dsdec_pkg::RAM_LO) + 1;
  logic [7:0] ram_ff [RAM_WORDS];
  logic [5:0] ram_idx;

  assign ram_idx = 6'(core_addr_i - dsdec_pkg::RAM_LO);

  // sixty-byte store, no reset so contents persist
  always_ff @(posedge clk_sys_i)
  begin
    if (core_wr_i && ram_hit)
      ram_ff[ram_idx] <= core_wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // rom window page

  logic [7:0] rom_window_page_ff;

  // no reset branch: value after reset is whatever was held
  // full-byte write only; the bit-op hazard is software's to avoid
  // a read-modify-write would see fill and corrupt the page
  always_ff @(posedge clk_sys_i)
  begin
    if (core_wr_i && wpage_hit)
      rom_window_page_ff <= core_wdata_i;
  end

  assign window_page_bits_o = rom_window_page_ff[6:0];

  ////////////////////////////////////////////////////////////////////////
  // rom address mux: core window read has priority over external readout

  logic [12:0] win_rom_addr;
  logic ext_blocked;
  logic win_rd;

  // page above low six address bits
  // thirteen-bit reach, truncated to rom fitted
  assign win_rom_addr = {rom_window_page_ff[6:0], core_addr_i[dsdec_pkg::WIN_LSB_W-1:0]};

  assign ext_blocked = readout_prot_fuse_i;

  // core window read owns the rom port this cycle
  assign win_rd = core_rd_i && win_hit;

  always_comb
  begin
    if (win_rd)
      rom_addr_o = ROM_AW'(win_rom_addr);
    else if (ext_read_req_i && !ext_blocked)
      rom_addr_o = ext_read_addr_i;
    else
      rom_addr_o = ROM_AW'(instruction_pointer_o);
  end

  logic [7:0] ext_data_ff;
  logic ext_blk_ff;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      ext_data_ff <= dsdec_pkg::READ_FILL;
      ext_blk_ff <= 1'b0;
    end
    else if (ext_read_req_i)
    begin
      ext_blk_ff <= ext_blocked;
      // a collision returns fill rather than the wrong byte
      if (ext_blocked || win_rd)
        ext_data_ff <= dsdec_pkg::READ_FILL;
      else
        ext_data_ff <= rom_data_i;
    end
  end

  assign ext_read_data_o = ext_data_ff;
  assign ext_read_blocked_o = ext_blk_ff;

  ////////////////////////////////////////////////////////////////////////
  // read data mux

  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;

  always_comb
  begin
    nxt_rdata = dsdec_pkg::READ_FILL;
    if (win_hit)
      nxt_rdata = rom_data_i;
    else if (ram_hit)
      nxt_rdata = ram_ff[ram_idx];
    else if (ptr1_hit)
      nxt_rdata = ptr_one_ff;
    else if (ptr2_hit)
      nxt_rdata = ptr_two_ff;
    else if (sd1_hit)
      nxt_rdata = sd_one_ff;
    else if (sd2_hit)
      nxt_rdata = sd_two_ff;
    else if (acc_hit)
      nxt_rdata = acc_ff;
    else if ((|psel) && !periph_ro_blocked)
      nxt_rdata = periph_rdata_i;
    // page register and holes read as fill
  end

  // registered answer, one cycle after the read strobe
  // held between reads so the core may sample late
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      rdata_ff <= 8'h00;
    else if (core_rd_i)
      rdata_ff <= nxt_rdata;
  end

  assign core_rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // program counter

  logic [11:0] pc_ff;
  logic [11:0] stk_ff [STACK_DEPTH];

  // twelve-bit counter wraps at 4096
  // pop outranks any pc op: a return reloads the pc
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      pc_ff <= dsdec_pkg::PC_RESET;
    else if (stk_op_i == dsdec_pkg::DSDEC_STK_POP)
      pc_ff <= stk_ff[0];
    else
    begin
      case (pc_op_i)
        dsdec_pkg::DSDEC_PC_LOAD: pc_ff <= pc_load_i;
        dsdec_pkg::DSDEC_PC_INC: pc_ff <= pc_ff + 12'h001;
        default: pc_ff <= pc_ff;
      endcase
    end
  end

  assign instruction_pointer_o = pc_ff;

  ////////////////////////////////////////////////////////////////////////
  // return stack: shifts, deepest level lost on overflow

  // six levels apart from data ram
  always_ff @(posedge clk_sys_i)
  begin
    case (stk_op_i)
      dsdec_pkg::DSDEC_STK_PUSH:
      begin
        stk_ff[0] <= pc_ff;
        for (int i = 1; i < STACK_DEPTH; i++)
          stk_ff[i] <= stk_ff[i-1];
      end
      dsdec_pkg::DSDEC_STK_POP:
      begin
        // deepest level keeps its value on pop
        for (int i = 0; i < STACK_DEPTH - 1; i++)
          stk_ff[i] <= stk_ff[i+1];
      end
      default:
      begin
      end
    endcase
  end

endmodule

// ---- bench/dsdec_monitor.sv ----
// port checker for the data-space decoder
module dsdec_monitor #(
  parameter int ROM_AW = 13
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] core_addr_i,
  input wire logic [7:0] core_wdata_i,
  input wire logic core_rd_i,
  input wire logic core_wr_i,
  input wire logic [7:0] core_rdata_o,
  input wire logic [ROM_AW-1:0] rom_addr_o,
  input wire logic [7:0] rom_data_i,
  input wire logic readout_prot_fuse_i,
  input wire logic ext_read_req_i,
  input wire logic [7:0] ext_read_data_o,
  input wire logic ext_read_blocked_o,
  input wire logic [dsdec_pkg::NUM_PERIPH-1:0] periph_sel_o,
  input wire logic periph_rd_o,
  input wire logic [6:0] window_page_bits_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic win;
  logic pg_wr;
  assign win = core_addr_i[7:6] == 2'b01;
  assign pg_wr = core_wr_i && core_addr_i == 8'hC9;
  ////////////////////////////////////////////////////////////
  a_win_addr: assert property (core_rd_i && win |-> rom_addr_o == ROM_AW'({window_page_bits_o, core_addr_i[5:0]}))
    else $error("window rom address wrong");
  a_win_data: assert property (core_rd_i && win |=> core_rdata_o == $past(rom_data_i))
    else $error("window read data wrong");
  a_page_load: assert property (pg_wr |=> {1'b0, window_page_bits_o} == ($past(core_wdata_i) & 8'h7F))
    else $error("page bits not loaded");
  a_page_keep: assert property (!pg_wr |=> $stable(window_page_bits_o))
    else $error("page bits moved without write");
  a_page_wo: assert property (core_rd_i && core_addr_i == 8'hC9 |=> core_rdata_o == 8'hFF)
    else $error("page register readable");
  a_intopt_wo: assert property (core_rd_i && core_addr_i == 8'hC8 |-> !periph_rd_o ##1 core_rdata_o == 8'hFF)
    else $error("interrupt option readable");
  a_acc_back: assert property ((core_wr_i && core_addr_i == 8'hFF) ##1 (core_rd_i && core_addr_i == 8'hFF)
    |=> core_rdata_o == $past(core_wdata_i, 2))
    else $error("accumulator read back wrong");
  a_port_sel: assert property (core_addr_i == 8'hCC |-> periph_sel_o == 14'h0020)
    else $error("port option select wrong");
  a_periph_rd: assert property (core_rd_i && core_addr_i == 8'hC0 |-> periph_rd_o && periph_sel_o[0])
    else $error("port data read strobe missing");
  a_fuse_block: assert property (ext_read_req_i && readout_prot_fuse_i |=> ext_read_blocked_o && ext_read_data_o == 8'hFF)
    else $error("protected readout not blocked");
  a_hole_read: assert property (core_rd_i && core_addr_i[7:6] == 2'b00 |=> core_rdata_o == 8'hFF)
    else $error("unimplemented read wrong");
  c_win: cover property (pg_wr ##1 core_rd_i && win);
  c_fuse: cover property (ext_read_req_i && readout_prot_fuse_i);
  c_acc: cover property (core_wr_i && core_addr_i == 8'hFF ##1 core_rd_i);
endmodule
bind dsdec_top dsdec_monitor #(.ROM_AW(ROM_AW)) dsdec_monitor_inst (.clk_sys_i, .reset_i, .core_addr_i, .core_wdata_i,
  .core_rd_i, .core_wr_i, .core_rdata_o, .rom_addr_o, .rom_data_i, .readout_prot_fuse_i, .ext_read_req_i,
  .ext_read_data_o, .ext_read_blocked_o, .periph_sel_o, .periph_rd_o, .window_page_bits_o);

// ---- bench/dsdec_rom_model.sv ----
// program rom model: address-derived bytes, fill above the fitted top
module dsdec_rom_model #(
  parameter int ROM_AW = 13,
  parameter int ROM_TOP = 8192
) (
  input wire logic [ROM_AW-1:0] rom_addr_i,
  output logic [7:0] rom_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign rom_data_o = (int'(rom_addr_i) >= ROM_TOP) ? 8'hFF : rom_addr_i[7:0] ^ {3'h0, rom_addr_i[12:8]};
endmodule

// ---- bench/data_space_decoder_rom_window_test.sv ----
// self-checking bench for the data-space decoder
module data_space_decoder_rom_window_test;
  timeunit 1ns;
  timeprecision 1ps;
  // rom fitted below the last page, so the top reads as fill
  localparam int TOP = 8128;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] core_addr_i = 8'h00, core_wdata_i = 8'h00, core_rdata_o, rom_data_i, ext_read_data_o, periph_rdata_i;
  logic core_rd_i = 1'b0, core_wr_i = 1'b0, readout_prot_fuse_i = 1'b0, ext_read_req_i = 1'b0;
  logic ext_read_blocked_o, periph_wr_o, periph_rd_o;
  logic [7:0] periph_wdata_o;
  logic [11:0] pc_load_i = 12'h000, instruction_pointer_o;
  logic [12:0] rom_addr_o, ext_read_addr_i = 13'h0123;
  logic [13:0] periph_sel_o;
  logic [6:0] window_page_bits_o;
  dsdec_pkg::dsdec_pc_op_t pc_op_i = dsdec_pkg::DSDEC_PC_HOLD;
  dsdec_pkg::dsdec_stk_op_t stk_op_i = dsdec_pkg::DSDEC_STK_NONE;
  int n_mismatch = 0;
  int total_checks = 0;
  assign periph_rdata_i = ~core_addr_i;
  dsdec_top #(.ROM_AW(13)) dsdec_top_inst (.clk_sys_i, .reset_i, .core_addr_i, .core_wdata_i, .core_rd_i, .core_wr_i,
    .core_rdata_o, .pc_op_i, .pc_load_i, .stk_op_i, .instruction_pointer_o, .rom_addr_o, .rom_data_i,
    .readout_prot_fuse_i, .ext_read_req_i, .ext_read_addr_i, .ext_read_data_o, .ext_read_blocked_o, .periph_sel_o,
    .periph_wr_o, .periph_rd_o, .periph_wdata_o, .periph_rdata_i, .window_page_bits_o);
  dsdec_rom_model #(.ROM_AW(13), .ROM_TOP(TOP)) dsdec_rom_model_inst (.rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rom_byte(input logic [12:0] a);
    return (int'(a) >= TOP) ? 8'hFF : a[7:0] ^ {3'h0, a[12:8]};
  endfunction
  // all bus tasks start and end on a falling edge
  // full-byte writes only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core_addr_i = a;
    core_wdata_i = d;
    core_wr_i = 1'b1;
    @(negedge clk_sys_i);
    core_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [12:0] ra);
    core_addr_i = a;
    core_rd_i = 1'b1;
    #1 ra = rom_addr_o;
    @(negedge clk_sys_i);
    core_rd_i = 1'b0;
    d = core_rdata_o;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_pc();
    pc_op_i = dsdec_pkg::DSDEC_PC_LOAD;
    pc_load_i = 12'hFFE;
    @(negedge clk_sys_i);
    pc_op_i = dsdec_pkg::DSDEC_PC_INC;
    repeat (2) @(negedge clk_sys_i);
    pc_op_i = dsdec_pkg::DSDEC_PC_HOLD;
    chk(16'(instruction_pointer_o), 16'h0000);
    for (int i = 1; i <= 6; i++)
    begin
      pc_op_i = dsdec_pkg::DSDEC_PC_LOAD;
      pc_load_i = 12'(i * 273);
      @(negedge clk_sys_i);
      pc_op_i = dsdec_pkg::DSDEC_PC_HOLD;
      stk_op_i = dsdec_pkg::DSDEC_STK_PUSH;
      @(negedge clk_sys_i);
      stk_op_i = dsdec_pkg::DSDEC_STK_NONE;
    end
    for (int i = 6; i >= 1; i--)
    begin
      stk_op_i = dsdec_pkg::DSDEC_STK_POP;
      @(negedge clk_sys_i);
      chk(16'(instruction_pointer_o), 16'(i * 273));
    end
    stk_op_i = dsdec_pkg::DSDEC_STK_NONE;
    $display("t_pc done");
  endtask
  task automatic t_window();
    logic [7:0] pg[5] = '{8'h28, 8'hA8, 8'h00, 8'h7F, 8'h7E};
    logic [7:0] ad[5] = '{8'h59, 8'h59, 8'h40, 8'h7F, 8'h7F};
    logic [12:0] ex[5] = '{13'h0A19, 13'h0A19, 13'h0000, 13'h1FFF, 13'h1FBF};
    logic [7:0] d;
    logic [12:0] ra;
    for (int i = 0; i < 5; i++)
    begin
      wr(8'hA0, pg[i]);
      @(negedge clk_sys_i);
      wr(8'hC9, pg[i]);
      rd(ad[i], d, ra);
      chk(16'(ra), 16'(ex[i]));
      chk(16'(d), 16'(rom_byte(ex[i])));
      chk(16'(window_page_bits_o), 16'(pg[i] & 8'h7F));
    end
    $display("t_window done");
  endtask
  task automatic t_regs();
    logic [7:0] ok[7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hBF, 8'hFF};
    logic [7:0] hole[4] = '{8'h20, 8'hC2, 8'hD9, 8'hC8};
    logic [7:0] d;
    logic [12:0] ra;
    for (int i = 0; i < 7; i++)
    begin
      wr(ok[i], ok[i] ^ 8'h5A);
      rd(ok[i], d, ra);
      chk(16'(d), 16'(ok[i] ^ 8'h5A));
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(hole[i], 8'h00);
      rd(hole[i], d, ra);
      chk(16'(d), 16'h00FF);
    end
    @(negedge clk_sys_i);
    rd(8'hC9, d, ra);
    chk(16'(d), 16'h00FF);
    $display("t_regs done");
  endtask
  task automatic t_periph();
    logic [7:0] ad[6] = '{8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD};
    int bit_no[6] = '{0, 1, 2, 3, 5, 6};
    logic [7:0] d;
    logic [12:0] ra;
    for (int i = 0; i < 6; i++)
    begin
      core_addr_i = ad[i];
      core_wdata_i = ~ad[i];
      core_wr_i = 1'b1;
      #1 chk(16'(periph_sel_o), 16'(14'h0001 << bit_no[i]));
      chk(16'({periph_wr_o, periph_rd_o}), 16'h0002);
      chk(16'(periph_wdata_o), {8'h00, ~ad[i]});
      @(negedge clk_sys_i);
      core_wr_i = 1'b0;
      rd(ad[i], d, ra);
      chk(16'(d), {8'h00, ~ad[i]});
    end
    $display("t_periph done");
  endtask
  task automatic t_readout();
    for (int f = 0; f < 2; f++)
    begin
      readout_prot_fuse_i = f[0];
      ext_read_req_i = 1'b1;
      @(negedge clk_sys_i);
      ext_read_req_i = 1'b0;
      chk(16'(ext_read_blocked_o), 16'(f));
      chk(16'(ext_read_data_o), f ? 16'h00FF : 16'(rom_byte(13'h0123)));
      @(negedge clk_sys_i);
    end
    $display("t_readout done");
  endtask
  task automatic t_reset_page();
    logic [7:0] d;
    logic [12:0] ra;
    wr(8'hC9, 8'h05);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    rd(8'h40, d, ra);
    chk(16'(ra), 16'h0140);
    chk(16'(d), 16'(rom_byte(13'h0140)));
    $display("t_reset_page done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge clk_sys_i);
    reset_i = 1'b0;
    wr(8'hC9, 8'h00);
    t_pc();
    t_window();
    t_regs();
    t_periph();
    t_readout();
    t_reset_page();
    report_and_stop();
  end
  initial
  begin
    #20us;
    n_mismatch++;
    report_and_stop();
  end
endmodule
